// file: monitor_mux_pkg.sv
// Constants shared by the monitor output selection logic
package monitor_mux_pkg;

	localparam int SEL_W    = 6;
	localparam int NUM_DIFF = 4;
	localparam int NUM_SRC  = 64;

	// Selector codes common to every general purpose output
	localparam logic [5:0] CODE_CMD_RAW       = 6'h00;
	localparam logic [5:0] CODE_CMD_RAW_INV   = 6'h01;
	localparam logic [5:0] CODE_REC_EARLY     = 6'h02;
	localparam logic [5:0] CODE_REC_EARLY_INV = 6'h03;
	localparam logic [5:0] CODE_POWER_RESET   = 6'h0A;
	localparam logic [5:0] CODE_CMD_IDLE      = 6'h0B;
	localparam logic [5:0] CODE_CMD_IDLE_SYNC = 6'h0C;
	localparam logic [5:0] CODE_SYNC_LOCK     = 6'h0D;
	localparam logic [5:0] CODE_PLL_LOCK      = 6'h0E;
	localparam int         CODE_HIT_FIRST     = 28;
	localparam logic [5:0] CODE_HIT_COMBINED  = 6'h20;
	localparam int         CODE_EVENT_FIRST   = 33;
	localparam int         NUM_EVENTS         = 10;
	localparam int         CODE_PATTERN_FIRST = 46;
	localparam int         CODE_DEBUG_FIRST   = 58;
	localparam logic [5:0] CODE_HIGH_Z        = 6'h3F;

	// Analog multiplexer settings
	localparam logic [5:0] IMUX_MAIN_REF     = 6'h00;
	localparam logic [5:0] IMUX_UNUSED_FIRST = 6'h20;
	localparam logic [5:0] IMUX_UNUSED_LAST  = 6'h3E;
	localparam logic [5:0] VMUX_ADC_REF      = 6'h00;
	localparam logic [5:0] VMUX_THRESH_ONE   = 6'h0A;
	localparam logic [5:0] VMUX_GND_FIRST    = 6'h13;
	localparam logic [5:0] VMUX_GND_LAST     = 6'h1E;
	localparam logic [5:0] VMUX_UNUSED_FIRST = 6'h28;
	localparam logic [5:0] VMUX_UNUSED_LAST  = 6'h3E;

	// Values after reset
	localparam logic [5:0] DEF_DIFF0   = 6'h00;
	localparam logic [5:0] DEF_DIFF1   = 6'h02;
	localparam logic [5:0] DEF_DIFF2   = 6'h0A;
	localparam logic [5:0] DEF_DIFF3   = 6'h0E;
	localparam logic [5:0] DEF_SINGLE  = 6'h0D;
	localparam logic [5:0] DEF_CURRENT = 6'h3F;
	localparam logic [5:0] DEF_VOLTAGE = 6'h3F;
	localparam logic [3:0] DEF_PATTERN = 4'h0;
	localparam logic       DEF_GPO_SEL = 1'b0;

	// Register byte addresses
	localparam logic [11:0] OFS_DIFF_SEL0   = 12'h000;
	localparam logic [11:0] OFS_SINGLE_SEL  = 12'h010;
	localparam logic [11:0] OFS_CURRENT_SEL = 12'h014;
	localparam logic [11:0] OFS_VOLTAGE_SEL = 12'h018;
	localparam logic [11:0] OFS_STATUS      = 12'h01C;
	localparam int          IDX_MERGE_CFG   = 70;
	localparam int          IDX_PATTERN     = 98;
	localparam logic [11:0] OFS_MERGE_CFG   = 12'(IDX_MERGE_CFG * 4);
	localparam logic [11:0] OFS_PATTERN     = 12'(IDX_PATTERN * 4);
	localparam int          POS_GPO_SEL     = 0;

	// Command activity timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int CMD_QUIET_NS  = 2000;
	localparam int QUIET_CYCLES  = (CMD_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUIET_W       = 6;

endpackage

// file: monitor_source_select.sv
// One registered 64-way source selector for a monitor output
`timescale 1ns/100ps

module monitor_source_select (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [63:0] sources,
	input  wire logic [5:0]  code,
	output logic             routed
);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			routed <= 1'b0;
		end else begin
			routed <= sources[code];
		end
	end

endmodule // monitor_source_select

// file: monitor_output_select_mux.sv
// Monitor output selection: APB registers, source table and analog mux codes
`timescale 1ns/100ps

// Operation
// - Four differential outputs and one single-ended output each have an independent selector.
// - All selectors decode one shared code table and may pick the same source together.
// - Code 0 routes the raw command input and is the reset choice of differential output 0.
// - Code 2 routes recovered command data before delay, code 3 its inverse; default of output 1.
// - Code 10 routes power-on reset (output 2 default), code 14 PLL lock (output 3 default).
// - Code 13 routes synchronizer lock and is the single-ended output's default.
// - Command activity goes low with no command transitions; its synchronized form resets the chip.
// - Codes 46 to 49 route bits 3 down to 0 of the static pattern register.
// - Codes 58 to 61 route bits 3 down to 0 of the chosen debug word.
// - Codes 33 to 42 route the command decoder event strobes and flags.
// - Codes 28 to 31 route hit-or lines 3 down to 0, code 32 their trigger-unit combination.
// - Current mux: 0 is the main reference, 32 to 62 unused, 63 high impedance.
// - Voltage mux: 0 converter reference, 10 threshold one, 19 to 30 ground, 63 high impedance.
module monitor_output_select_mux (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmd_raw,
	input  wire logic        cmd_rec_early,
	input  wire logic        power_on_reset,
	input  wire logic        sync_lock,
	input  wire logic        pll_lock,
	input  wire logic [3:0]  hit_flag_or,
	input  wire logic        hit_flag_combined,
	input  wire logic [9:0]  decoder_events,
	input  wire logic [15:0] phase_det_word,
	input  wire logic [15:0] pll_deser_word,
	input  wire logic [63:0] spare_sources,
	output logic [3:0]       general_diff_outputs,
	output logic             general_single_output,
	output logic [5:0]       current_mux_sel,
	output logic             current_mux_oe_n,
	output logic             current_mux_unused,
	output logic [5:0]       voltage_mux_sel,
	output logic             voltage_mux_oe_n,
	output logic             voltage_mux_ground,
	output logic             voltage_mux_unused,
	output logic             cmd_activity,
	output logic             chip_reset_n
);

	function automatic logic in_range(input logic [5:0] code, input logic [5:0] lo,
		input logic [5:0] hi);
		in_range = (code >= lo) && (code <= hi);
	endfunction

	// Four bits of the debug word sit at one phase of a 4x sampled word
	function automatic logic [3:0] phase_bits(input logic [15:0] word);
		phase_bits = {word[12], word[8], word[4], word[0]};
	endfunction

	localparam int QUIET_W = monitor_mux_pkg::QUIET_W;

	logic [5:0]  diff_sel [0:3];
	logic [5:0]  single_sel;
	logic [5:0]  current_code;
	logic [5:0]  voltage_code;
	logic [3:0]  pattern;
	logic        gpo_sel;
	logic [3:0]  chosen_debug_word;
	logic [63:0] sources;
	logic [4:0]  diff_routed;
	logic        cmd_prev;
	logic [QUIET_W-1:0] quiet_count;
	logic        idle_meta;
	logic        idle_sync;
	logic        setup;
	logic        wr_access;
	logic [31:0] next_rdata;
	logic        next_err;

	assign setup     = psel && !penable;
	assign wr_access = psel && penable && pready && pwrite;

	// Register writes take effect only at the completing access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diff_sel[0] <= monitor_mux_pkg::DEF_DIFF0;
			diff_sel[1] <= monitor_mux_pkg::DEF_DIFF1;
			diff_sel[2] <= monitor_mux_pkg::DEF_DIFF2;
			diff_sel[3] <= monitor_mux_pkg::DEF_DIFF3;
			single_sel  <= monitor_mux_pkg::DEF_SINGLE;
		end else if (wr_access) begin
			for (int i = 0; i < monitor_mux_pkg::NUM_DIFF; i++) begin
				if (paddr == monitor_mux_pkg::OFS_DIFF_SEL0 + 12'(i * 4)) begin
					diff_sel[i] <= pwdata[5:0];
				end
			end
			if (paddr == monitor_mux_pkg::OFS_SINGLE_SEL) begin
				single_sel <= pwdata[5:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			current_code <= monitor_mux_pkg::DEF_CURRENT;
			voltage_code <= monitor_mux_pkg::DEF_VOLTAGE;
		end else if (wr_access) begin
			if (paddr == monitor_mux_pkg::OFS_CURRENT_SEL) begin
				current_code <= pwdata[5:0];
			end
			if (paddr == monitor_mux_pkg::OFS_VOLTAGE_SEL) begin
				voltage_code <= pwdata[5:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pattern <= monitor_mux_pkg::DEF_PATTERN;
			gpo_sel <= monitor_mux_pkg::DEF_GPO_SEL;
		end else if (wr_access) begin
			if (paddr == monitor_mux_pkg::OFS_PATTERN) begin
				pattern <= pwdata[3:0];
			end
			if (paddr == monitor_mux_pkg::OFS_MERGE_CFG) begin
				gpo_sel <= pwdata[monitor_mux_pkg::POS_GPO_SEL];
			end
		end
	end

	// Read data and error are prepared in the setup cycle; every access has no wait state
	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err   = 1'b0;
		case (paddr)
			monitor_mux_pkg::OFS_DIFF_SEL0:        next_rdata[5:0] = diff_sel[0];
			monitor_mux_pkg::OFS_DIFF_SEL0 + 12'h4: next_rdata[5:0] = diff_sel[1];
			monitor_mux_pkg::OFS_DIFF_SEL0 + 12'h8: next_rdata[5:0] = diff_sel[2];
			monitor_mux_pkg::OFS_DIFF_SEL0 + 12'hC: next_rdata[5:0] = diff_sel[3];
			monitor_mux_pkg::OFS_SINGLE_SEL:       next_rdata[5:0] = single_sel;
			monitor_mux_pkg::OFS_CURRENT_SEL:      next_rdata[5:0] = current_code;
			monitor_mux_pkg::OFS_VOLTAGE_SEL:      next_rdata[5:0] = voltage_code;
			monitor_mux_pkg::OFS_PATTERN:          next_rdata[3:0] = pattern;
			monitor_mux_pkg::OFS_MERGE_CFG:
				next_rdata[monitor_mux_pkg::POS_GPO_SEL] = gpo_sel;
			monitor_mux_pkg::OFS_STATUS:
				next_rdata[6:0] = {chip_reset_n, cmd_activity, general_single_output,
					general_diff_outputs};
			default:                               next_err = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && next_err;
			if (setup && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

	// Command activity: low after a quiet period with no edges on the command input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_prev     <= 1'b0;
			quiet_count  <= '0;
			cmd_activity <= 1'b1;
		end else begin
			cmd_prev <= cmd_raw;
			if (cmd_raw != cmd_prev) begin
				quiet_count  <= '0;
				cmd_activity <= 1'b1;
			end else if (quiet_count == QUIET_W'(monitor_mux_pkg::QUIET_CYCLES - 1)) begin
				cmd_activity <= 1'b0;
			end else begin
				quiet_count <= quiet_count + QUIET_W'(1);
			end
		end
	end

	// Synchronized idle form, registered once more, drives the chip reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_meta    <= 1'b1;
			idle_sync    <= 1'b1;
			chip_reset_n <= 1'b1;
		end else begin
			idle_meta    <= cmd_activity;
			idle_sync    <= idle_meta;
			chip_reset_n <= idle_sync;
		end
	end

	assign chosen_debug_word = gpo_sel ? phase_bits(phase_det_word)
		: phase_bits(pll_deser_word);

	// Shared code table seen by every selector
	always_comb begin
		sources = spare_sources;
		sources[monitor_mux_pkg::CODE_CMD_RAW]       = cmd_raw;
		sources[monitor_mux_pkg::CODE_CMD_RAW_INV]   = ~cmd_raw;
		sources[monitor_mux_pkg::CODE_REC_EARLY]     = cmd_rec_early;
		sources[monitor_mux_pkg::CODE_REC_EARLY_INV] = ~cmd_rec_early;
		sources[monitor_mux_pkg::CODE_POWER_RESET]   = power_on_reset;
		sources[monitor_mux_pkg::CODE_CMD_IDLE]      = cmd_activity;
		sources[monitor_mux_pkg::CODE_CMD_IDLE_SYNC] = idle_sync;
		sources[monitor_mux_pkg::CODE_SYNC_LOCK]     = sync_lock;
		sources[monitor_mux_pkg::CODE_PLL_LOCK]      = pll_lock;
		for (int i = 0; i < 4; i++) begin
			sources[monitor_mux_pkg::CODE_HIT_FIRST + i]     = hit_flag_or[3 - i];
			sources[monitor_mux_pkg::CODE_PATTERN_FIRST + i] = pattern[3 - i];
			sources[monitor_mux_pkg::CODE_DEBUG_FIRST + i]   = chosen_debug_word[3 - i];
		end
		sources[monitor_mux_pkg::CODE_HIT_COMBINED] = hit_flag_combined;
		for (int i = 0; i < monitor_mux_pkg::NUM_EVENTS; i++) begin
			sources[monitor_mux_pkg::CODE_EVENT_FIRST + i] = decoder_events[i];
		end
	end

	// One dedicated selector per output
	genvar g;
	generate
		for (g = 0; g <= monitor_mux_pkg::NUM_DIFF; g++) begin : g_sel
			monitor_source_select u_sel (
				.pclk    (pclk),
				.presetn (presetn),
				.sources (sources),
				.code    (g < monitor_mux_pkg::NUM_DIFF ? diff_sel[g % 4] : single_sel),
				.routed  (diff_routed[g])
			);
		end
	endgenerate

	assign general_diff_outputs  = diff_routed[3:0];
	assign general_single_output = diff_routed[4];

	// Analog mux codes and their decoded pad controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			current_mux_sel    <= monitor_mux_pkg::DEF_CURRENT;
			current_mux_oe_n   <= 1'b1;
			current_mux_unused <= 1'b0;
		end else begin
			current_mux_sel    <= current_code;
			current_mux_oe_n   <= (current_code == monitor_mux_pkg::CODE_HIGH_Z);
			current_mux_unused <= in_range(current_code, monitor_mux_pkg::IMUX_UNUSED_FIRST,
				monitor_mux_pkg::IMUX_UNUSED_LAST);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			voltage_mux_sel    <= monitor_mux_pkg::DEF_VOLTAGE;
			voltage_mux_oe_n   <= 1'b1;
			voltage_mux_ground <= 1'b0;
			voltage_mux_unused <= 1'b0;
		end else begin
			voltage_mux_sel    <= voltage_code;
			voltage_mux_oe_n   <= (voltage_code == monitor_mux_pkg::CODE_HIGH_Z);
			voltage_mux_ground <= in_range(voltage_code, monitor_mux_pkg::VMUX_GND_FIRST,
				monitor_mux_pkg::VMUX_GND_LAST);
			voltage_mux_unused <= in_range(voltage_code, monitor_mux_pkg::VMUX_UNUSED_FIRST,
				monitor_mux_pkg::VMUX_UNUSED_LAST);
		end
	end

	// Checks on the selector, analog mux and idle reset paths
	// Sampled reset in an antecedent skips the release edge, where the selector flops still hold
	a_diff0_default: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && diff_sel[0] == 6'h00) |=> (general_diff_outputs[0] == $past(cmd_raw)))
		else $error("output 0 not following raw command");
	a_early_inverse: assert property (@(posedge pclk) disable iff (!presetn)
		(diff_sel[1] == 6'h03) |=> (general_diff_outputs[1] != $past(cmd_rec_early)))
		else $error("code 3 not inverted recovered data");
	a_pll_lock_out: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && diff_sel[3] == 6'h0E) |=> (general_diff_outputs[3] == $past(pll_lock)))
		else $error("code 14 not pll lock");
	a_single_sync: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && single_sel == 6'h0D) |=> (general_single_output == $past(sync_lock)))
		else $error("code 13 not sync lock");
	a_shared_source: assert property (@(posedge pclk) disable iff (!presetn)
		(diff_sel[2] == single_sel) |=> (general_diff_outputs[2] == general_single_output))
		else $error("same code gave different outputs");
	a_idle_reset: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(cmd_activity) |-> ##3 !chip_reset_n)
		else $error("idle did not reach chip reset in three cycles");
	a_pattern_bit: assert property (@(posedge pclk) disable iff (!presetn)
		(diff_sel[0] == 6'h2E) |=> (general_diff_outputs[0] == $past(pattern[3])))
		else $error("code 46 not pattern bit 3");
	a_debug_bit: assert property (@(posedge pclk) disable iff (!presetn)
		(single_sel == 6'h3D) |=> (general_single_output == $past(chosen_debug_word[0])))
		else $error("code 61 not debug bit 0");
	a_event_route: assert property (@(posedge pclk) disable iff (!presetn)
		(diff_sel[2] == 6'h21) |=> (general_diff_outputs[2] == $past(decoder_events[0])))
		else $error("code 33 not first decoder event");
	a_hit_route: assert property (@(posedge pclk) disable iff (!presetn)
		(diff_sel[1] == 6'h1C) |=> (general_diff_outputs[1] == $past(hit_flag_or[3])))
		else $error("code 28 not hit line 3");
	a_imux_highz: assert property (@(posedge pclk) disable iff (!presetn)
		(current_code == 6'h3F) |=> current_mux_oe_n)
		else $error("current mux not released at 63");
	a_vmux_ground: assert property (@(posedge pclk) disable iff (!presetn)
		(voltage_code == 6'h14) |=> (voltage_mux_ground && voltage_mux_oe_n == 1'b0))
		else $error("voltage mux 20 not ground");
	a_write_apply: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_access && paddr == 12'h010) |=> (single_sel == $past(pwdata[5:0]))
		##1 (general_single_output == $past(sources[single_sel])))
		else $error("selector write not applied next cycle");
	a_others_kept: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_access && paddr == 12'h010) |=> $stable(diff_sel[0]) && $stable(diff_sel[3]))
		else $error("single select write disturbed a differential selector");
	a_power_reset_out: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && diff_sel[2] == 6'h0A) |=>
		(general_diff_outputs[2] == $past(power_on_reset)))
		else $error("code 10 not power-on reset");
	a_early_direct: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && diff_sel[1] == 6'h02) |=>
		(general_diff_outputs[1] == $past(cmd_rec_early)))
		else $error("code 2 not recovered data");
	a_raw_single: assert property (@(posedge pclk) disable iff (!presetn)
		(single_sel == 6'h00) |=> (general_single_output == $past(cmd_raw)))
		else $error("code 0 not raw command on single output");
	a_hit_combined: assert property (@(posedge pclk) disable iff (!presetn)
		(diff_sel[3] == 6'h20) |=> (general_diff_outputs[3] == $past(hit_flag_combined)))
		else $error("code 32 not combined hit");
	a_event_last: assert property (@(posedge pclk) disable iff (!presetn)
		(diff_sel[0] == 6'h2A) |=> (general_diff_outputs[0] == $past(decoder_events[9])))
		else $error("code 42 not last decoder event");
	a_pattern_low: assert property (@(posedge pclk) disable iff (!presetn)
		(single_sel == 6'h31) |=> (general_single_output == $past(pattern[0])))
		else $error("code 49 not pattern bit 0");
	a_debug_high: assert property (@(posedge pclk) disable iff (!presetn)
		(diff_sel[3] == 6'h3A) |=> (general_diff_outputs[3] == $past(chosen_debug_word[3])))
		else $error("code 58 not debug bit 3");
	a_idle_sync_out: assert property (@(posedge pclk) disable iff (!presetn)
		(single_sel == 6'h0C) |=> (general_single_output == $past(idle_sync)))
		else $error("code 12 not synchronized idle");
	a_imux_unused: assert property (@(posedge pclk) disable iff (!presetn)
		(current_code >= 6'h20 && current_code <= 6'h3E) |=>
		(current_mux_unused && !current_mux_oe_n))
		else $error("current mux unused range not flagged");
	a_vmux_highz: assert property (@(posedge pclk) disable iff (!presetn)
		(voltage_code == 6'h3F) |=> (voltage_mux_oe_n && !voltage_mux_ground))
		else $error("voltage mux not released at 63");
	a_diff_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_access && paddr == 12'h000) |=> (diff_sel[0] == $past(pwdata[5:0])))
		else $error("differential selector write not held");

endmodule // monitor_output_select_mux

// file: monitor_pad_probe.sv
// Pad probe standing in for the test equipment on the monitor outputs
`timescale 1ns/100ps

module monitor_pad_probe (
	input  wire logic       pclk,
	input  wire logic [3:0] diff_pads,
	input  wire logic       single_pad,
	output logic [3:0]      seen_diff,
	output logic            seen_single
);
	// Equipment samples every pad on each rising core clock edge
	always_ff @(posedge pclk) begin
		seen_diff   <= diff_pads;
		seen_single <= single_pad;
	end
endmodule // monitor_pad_probe

// file: monitor_output_select_mux_bench.sv
// Self-checking bench for the monitor output selection block
`timescale 1ns/100ps

module monitor_output_select_mux_bench;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr;
	logic        cmd_raw, cmd_rec_early, power_on_reset, sync_lock, pll_lock;
	logic [3:0]  hit_flag_or;
	logic        hit_flag_combined;
	logic [9:0]  decoder_events;
	logic [15:0] phase_det_word, pll_deser_word;
	logic [63:0] spare_sources;
	logic [3:0]  general_diff_outputs;
	logic        general_single_output;
	logic [5:0]  current_mux_sel, voltage_mux_sel;
	logic        current_mux_oe_n, current_mux_unused;
	logic        voltage_mux_oe_n, voltage_mux_ground, voltage_mux_unused;
	logic        cmd_activity, chip_reset_n;
	logic [3:0]  seen_diff;
	logic        seen_single;
	int          mismatches, total_checks, n;
	logic [31:0] q;
	logic        e;
	logic [3:0]  v4;
	logic [9:0]  v10;
	logic [5:0]  defs [5] = '{6'h00, 6'h02, 6'h0A, 6'h0E, 6'h0D};
	logic [5:0]  cc [7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0A, 6'h0D, 6'h0E};
	logic        ce [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

	monitor_output_select_mux u_monitor_output_select_mux (
		.pclk                  (pclk),
		.presetn               (presetn),
		.psel                  (psel),
		.penable               (penable),
		.pwrite                (pwrite),
		.paddr                 (paddr),
		.pwdata                (pwdata),
		.prdata                (prdata),
		.pready                (pready),
		.pslverr               (pslverr),
		.cmd_raw               (cmd_raw),
		.cmd_rec_early         (cmd_rec_early),
		.power_on_reset        (power_on_reset),
		.sync_lock             (sync_lock),
		.pll_lock              (pll_lock),
		.hit_flag_or           (hit_flag_or),
		.hit_flag_combined     (hit_flag_combined),
		.decoder_events        (decoder_events),
		.phase_det_word        (phase_det_word),
		.pll_deser_word        (pll_deser_word),
		.spare_sources         (spare_sources),
		.general_diff_outputs  (general_diff_outputs),
		.general_single_output (general_single_output),
		.current_mux_sel       (current_mux_sel),
		.current_mux_oe_n      (current_mux_oe_n),
		.current_mux_unused    (current_mux_unused),
		.voltage_mux_sel       (voltage_mux_sel),
		.voltage_mux_oe_n      (voltage_mux_oe_n),
		.voltage_mux_ground    (voltage_mux_ground),
		.voltage_mux_unused    (voltage_mux_unused),
		.cmd_activity          (cmd_activity),
		.chip_reset_n          (chip_reset_n)
	);

	monitor_pad_probe u_monitor_pad_probe (
		.pclk       (pclk),
		.diff_pads  (general_diff_outputs),
		.single_pad (general_single_output),
		.seen_diff  (seen_diff),
		.seen_single(seen_single)
	);

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; ends one edge after completion so psel never toggles twice
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			mismatches++;
			$display("[FAIL] %0t no pready", $time);
			finish_test();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
		xfer(1'b0, a, 32'h0);
		chk(q, x, "read data");
		chk({31'h0, e}, {31'h0, xe}, "read error");
	endtask

	// Same code to every output, checked one edge after the last write
	task automatic route(input logic [5:0] c, input logic x);
		for (int i = 0; i < 4; i++)
			wr(12'(4 * i), 32'(c));
		wr(monitor_mux_pkg::OFS_SINGLE_SEL, 32'(c));
		#1;
		chk(32'({general_diff_outputs, general_single_output}), 32'({5{x}}), "route");
		@(posedge pclk);
	endtask

	task automatic imux(input logic [5:0] c, input logic [1:0] x);
		wr(monitor_mux_pkg::OFS_CURRENT_SEL, 32'(c));
		#1;
		chk({24'h0, current_mux_sel, current_mux_oe_n, current_mux_unused}, {24'h0, c, x}, "imux");
		@(posedge pclk);
	endtask

	task automatic vmux(input logic [5:0] c, input logic [2:0] x);
		wr(monitor_mux_pkg::OFS_VOLTAGE_SEL, 32'(c));
		#1;
		chk({23'h0, voltage_mux_sel, voltage_mux_oe_n, voltage_mux_ground, voltage_mux_unused},
			{23'h0, c, x}, "vmux");
		@(posedge pclk);
	endtask

	initial begin : main
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{cmd_raw, cmd_rec_early, power_on_reset, pll_lock, sync_lock} = 5'b10101;
		{hit_flag_or, hit_flag_combined, decoder_events} = '0;
		phase_det_word = 16'h1010;
		pll_deser_word = 16'h0101;
		spare_sources = 64'h0;
		mismatches = 0;
		total_checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		chk(32'({general_diff_outputs, general_single_output}), 32'h0B, "defaults");
		@(posedge pclk);
		#1;
		chk(32'({seen_diff, seen_single}), 32'h0B, "pads");
		@(posedge pclk);
		for (int i = 0; i < 5; i++)
			rd_chk(12'(4 * i), 32'(defs[i]), 1'b0);
		rd_chk(monitor_mux_pkg::OFS_CURRENT_SEL, 32'h3F, 1'b0);
		rd_chk(12'h0FC, 32'h0, 1'b1);
		{cmd_raw, cmd_rec_early, power_on_reset, pll_lock, sync_lock} <= 5'b01010;
		repeat (2) @(posedge pclk);
		#1;
		chk(32'({general_diff_outputs, general_single_output}), 32'h14, "defaults");
		@(posedge pclk);
		for (int i = 0; i < 7; i++)
			route(cc[i], ce[i]);
		for (int p = 0; p < 2; p++) begin
			v4 = p ? 4'hA : 4'h5;
			v10 = p ? 10'h2A5 : 10'h15A;
			hit_flag_or <= v4;
			hit_flag_combined <= p[0];
			decoder_events <= v10;
			for (int k = 0; k < 4; k++)
				route(6'(28 + k), v4[3 - k]);
			route(6'h20, p[0]);
			for (int k = 0; k < 10; k++)
				route(6'(33 + k), v10[k]);
			wr(monitor_mux_pkg::OFS_PATTERN, 32'(v4));
			rd_chk(monitor_mux_pkg::OFS_PATTERN, 32'(v4), 1'b0);
			for (int k = 0; k < 4; k++)
				route(6'(46 + k), v4[3 - k]);
			// Bits 12,8,4,0 of phase word give A, of pll word give 5
			wr(monitor_mux_pkg::OFS_MERGE_CFG, 32'(p));
			for (int k = 0; k < 4; k++)
				route(6'(58 + k), v4[3 - k]);
		end
		wr(12'h004, 32'h0E);
		#1;
		chk(32'(general_diff_outputs), 32'h2, "independent");
		@(posedge pclk);
		imux(6'h00, 2'b00);
		imux(6'h1F, 2'b00);
		imux(6'h20, 2'b01);
		imux(6'h3E, 2'b01);
		imux(6'h3F, 2'b10);
		vmux(6'h00, 3'b000);
		vmux(6'h0A, 3'b000);
		vmux(6'h12, 3'b000);
		vmux(6'h13, 3'b010);
		vmux(6'h14, 3'b010);
		vmux(6'h1E, 3'b010);
		vmux(6'h28, 3'b001);
		vmux(6'h3F, 3'b100);
		cmd_raw <= ~cmd_raw;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (cmd_activity !== 1'b0 && n < 40);
		chk(32'(n >= 20 && n <= 22), 32'h1, "idle time");
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (chip_reset_n !== 1'b0 && n < 10);
		chk(32'(n), 32'h3, "reset lag");
		route(6'h0B, 1'b0);
		route(6'h0C, 1'b0);
		cmd_raw <= ~cmd_raw;
		repeat (6) @(posedge pclk);
		#1;
		chk(32'({cmd_activity, chip_reset_n}), 32'h3, "wake");
		finish_test();
	end
endmodule // monitor_output_select_mux_bench
